//--- design/vfi_flag_group.v
// Purpose: three sticky per-channel under-voltage flags, write one to clear
// Assumes: fault and enable levels already in the sys_clk domain
// Notes:   channel bits 0..2 map to monitor inputs two, three and four
`timescale 1ns/1ps
`include "vfi_map.vh"

module vfi_flag_group (
   input  wire       sys_clk,
   input  wire       rst_b,
   input  wire [2:0] fault_now,
   input  wire [2:0] irq_enable,
   input  wire       clear_strobe,
   input  wire [2:0] clear_mask,
   output reg  [2:0] flags
);

   reg [2:0] next_flags;

   // set wins over a clear in the same cycle; a clear is refused while the fault persists
   always @* begin
      next_flags = flags & ~({3{clear_strobe}} & clear_mask & ~fault_now);
      next_flags = next_flags | fault_now;
      next_flags = next_flags & irq_enable;
   end

   always @(posedge sys_clk) begin
      if (!rst_b) begin
         flags <= `VFI_RST_FLAGS;
      end else begin
         flags <= next_flags;
      end
   end

endmodule // vfi_flag_group

//--- design/vfi_map.vh
// Purpose: register offsets, field positions and reset values for the voltage fault status block
// Assumes: 8-bit registers in bank 0
// Notes:   definitions only
`ifndef VFI_MAP_VH
`define VFI_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define VFI_OFS_GLOBAL_SRC    8'h10
`define VFI_OFS_SUMMARY       8'h11
`define VFI_OFS_FAST_UV       8'h12
`define VFI_OFS_SLOW_UV       8'h14
`define VFI_OFS_FAST_OV       8'h16
`define VFI_OFS_SLOW_OV       8'h18

// ****************************************
// fields
// ****************************************
`define VFI_SUM_FAST_UV_BIT   0
`define VFI_SUM_SLOW_UV_BIT   1
`define VFI_SUM_FAST_OV_BIT   2
`define VFI_SUM_SLOW_OV_BIT   3
`define VFI_SRC_MONITOR_BIT   0
`define VFI_CHAN_LSB          1
`define VFI_CHAN_MSB          3
`define VFI_BANK_STATUS       1'b0

// ****************************************
// reset values
// ****************************************
`define VFI_RST_FLAGS         3'h0
`define VFI_RST_BYTE          8'h00

`endif

//--- design/vfi_sync.v
// Purpose: two-stage synchroniser for a group of level inputs
// Assumes: inputs come from outside the sys_clk domain
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps

module vfi_sync #(
   parameter WIDTH = 3
) (
   input  wire             sys_clk,
   input  wire             rst_b,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage_one;

   always @(posedge sys_clk) begin
      if (!rst_b) begin
         stage_one <= {WIDTH{1'b0}};
         sync_out  <= {WIDTH{1'b0}};
      end else begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end

endmodule // vfi_sync

//--- design/vfi_voltage_fault_irq.v
// Purpose: under-voltage interrupt status registers and fault summary for a supply supervisor
// Assumes: serial bus front end delivers byte reads and writes as strobes on sys_clk
// Notes:   over-voltage flags arrive ready made from elsewhere; only their OR is reported
//
// How it works
// - summary bit 3 ORs slow over-voltage flags
// - summary bit 2 ORs fast over-voltage flags
// - summary bit 1 ORs slow under-voltage flags
// - summary bit 0 ORs fast under-voltage flags
// - comparator faults fast, ADC faults slow, separate
// - summary at 0x11, under-voltage bits reset zero, bits 7-4 zero
// - fast flags set on comparator under-voltage
// - slow flags set on ADC under-voltage
// - flags stay set after supply recovers
// - only a written one or a low enable bit clears a flag
// - fast clear needs fault condition removed
// - slow clear needs fault condition removed
// - disabled fast channel reads zero
// - disabled slow channel reads zero
// - fast flags at 0x12, reserved bits zero
// - slow flags at 0x14, reserved bits zero
// - global source bit 0 ORs summary
// - registers answer only in bank 0
`timescale 1ns/1ps
`include "vfi_map.vh"

module vfi_voltage_fault_irq (
   input  wire       sys_clk,
   input  wire       rst_b,
   input  wire [2:0] fast_undervolt_cmp,
   input  wire [2:0] slow_undervolt_adc,
   input  wire [2:0] fast_undervolt_irq_enable,
   input  wire [2:0] slow_undervolt_irq_enable,
   input  wire [7:0] fast_overvolt_flags,
   input  wire [7:0] slow_overvolt_flags,
   input  wire       bank_select,
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   output wire       reg_hit,
   output wire [2:0] fast_undervolt_flags_out,
   output wire [2:0] slow_undervolt_flags_out,
   output wire       global_irq_monitor
);

   // ****************************************
   // decode helpers
   // ****************************************
   // single-offset matches, shared by the acknowledge, write and read decodes
   function hit_summary;
      input [7:0] addr;
      begin
         hit_summary = (addr == `VFI_OFS_SUMMARY);
      end
   endfunction

   function hit_fast;
      input [7:0] addr;
      begin
         hit_fast = (addr == `VFI_OFS_FAST_UV);
      end
   endfunction

   function hit_slow;
      input [7:0] addr;
      begin
         hit_slow = (addr == `VFI_OFS_SLOW_UV);
      end
   endfunction

   function hit_source;
      input [7:0] addr;
      begin
         hit_source = (addr == `VFI_OFS_GLOBAL_SRC);
      end
   endfunction

   // any bit of a register set, shared by every summary bit
   function any_set;
      input [7:0] v;
      begin
         any_set = |v;
      end
   endfunction

   // only the channel bits of a written byte may reach the flags
   function [2:0] chan_bits;
      input [7:0] v;
      begin
         chan_bits = v[`VFI_CHAN_MSB:`VFI_CHAN_LSB];
      end
   endfunction

   function is_own_reg;
      input [7:0] addr;
      begin
         if (hit_summary(addr)) begin
            is_own_reg = 1'b1;
         end else if (hit_fast(addr)) begin
            is_own_reg = 1'b1;
         end else if (hit_slow(addr)) begin
            is_own_reg = 1'b1;
         end else if (hit_source(addr)) begin
            is_own_reg = 1'b1;
         end else begin
            is_own_reg = 1'b0;
         end
      end
   endfunction

   // channel flags sit in bits 3..1, reserved bits forced low
   function [7:0] place_flags;
      input [2:0] f;
      begin
         place_flags = {4'h0, f, 1'b0};
      end
   endfunction

   // ****************************************
   // synchronised fault sources
   // ****************************************
   wire [2:0] fast_fault;
   wire [2:0] slow_fault;
   wire [2:0] fast_enable;
   wire [2:0] slow_enable;

   // comparator and ADC sources kept apart end to end
   // one synchroniser per source, so neither group can borrow the other's timing
   vfi_sync #(.WIDTH(3)) u_sync_fast (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .async_in (fast_undervolt_cmp),
      .sync_out (fast_fault)
   );

   vfi_sync #(.WIDTH(3)) u_sync_slow (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .async_in (slow_undervolt_adc),
      .sync_out (slow_fault)
   );

   // enables are register bits on the same clock, no synchroniser
   assign fast_enable = fast_undervolt_irq_enable;
   assign slow_enable = slow_undervolt_irq_enable;

   // ****************************************
   // write decode
   // ****************************************
   wire       in_bank;
   wire       wr_ok;
   wire       sel_summary;
   wire       sel_fast;
   wire       sel_slow;
   wire       sel_source;
   reg        fast_clr;
   reg        slow_clr;
   wire [2:0] clr_mask;

   assign in_bank     = (bank_select == `VFI_BANK_STATUS);
   assign wr_ok       = reg_wr & in_bank;
   assign sel_summary = in_bank & hit_summary(reg_addr);
   assign sel_fast    = in_bank & hit_fast(reg_addr);
   assign sel_slow    = in_bank & hit_slow(reg_addr);
   assign sel_source  = in_bank & hit_source(reg_addr);
   assign clr_mask    = chan_bits(reg_wdata);

   // summary and source writes fall through untouched, both are read only
   always @* begin
      fast_clr = 1'b0;
      slow_clr = 1'b0;
      if (wr_ok && sel_fast) begin
         fast_clr = 1'b1;
      end else if (wr_ok && sel_slow) begin
         slow_clr = 1'b1;
      end
   end

   // ****************************************
   // flag groups
   // ****************************************
   wire [2:0] fast_flags;
   wire [2:0] slow_flags;

   vfi_flag_group u_fast (
      .sys_clk      (sys_clk),
      .rst_b        (rst_b),
      .fault_now    (fast_fault),
      .irq_enable   (fast_enable),
      .clear_strobe (fast_clr),
      .clear_mask   (clr_mask),
      .flags        (fast_flags)
   );

   vfi_flag_group u_slow (
      .sys_clk      (sys_clk),
      .rst_b        (rst_b),
      .fault_now    (slow_fault),
      .irq_enable   (slow_enable),
      .clear_strobe (slow_clr),
      .clear_mask   (clr_mask),
      .flags        (slow_flags)
   );

   // ****************************************
   // summary
   // ****************************************
   wire [7:0] summary;
   wire       fast_undervolt_any;
   wire       slow_undervolt_any;
   wire       fast_overvolt_any;
   wire       slow_overvolt_any;

   assign fast_undervolt_any = any_set({5'h00, fast_flags});
   assign slow_undervolt_any = any_set({5'h00, slow_flags});
   assign fast_overvolt_any  = any_set(fast_overvolt_flags);
   assign slow_overvolt_any  = any_set(slow_overvolt_flags);

   assign summary[`VFI_SUM_FAST_UV_BIT] = fast_undervolt_any;
   assign summary[`VFI_SUM_SLOW_UV_BIT] = slow_undervolt_any;
   assign summary[`VFI_SUM_FAST_OV_BIT] = fast_overvolt_any;
   assign summary[`VFI_SUM_SLOW_OV_BIT] = slow_overvolt_any;
   assign summary[7:4]                  = 4'h0;

   assign global_irq_monitor       = any_set(summary);
   assign fast_undervolt_flags_out = fast_flags;
   assign slow_undervolt_flags_out = slow_flags;
   assign reg_hit                  = in_bank & is_own_reg(reg_addr);

   // ****************************************
   // read path
   // ****************************************
   reg  [7:0] next_rdata;
   wire [7:0] fast_image;
   wire [7:0] slow_image;
   wire [7:0] source_image;

   assign fast_image   = place_flags(fast_flags);
   assign slow_image   = place_flags(slow_flags);
   assign source_image = {7'h00, global_irq_monitor};

   // unmapped offsets and the other bank read as zero rather than floating
   always @* begin
      next_rdata = `VFI_RST_BYTE;
      if (!in_bank) begin
         next_rdata = `VFI_RST_BYTE;
      end else if (sel_summary) begin
         next_rdata = summary;
      end else if (sel_fast) begin
         next_rdata = fast_image;
      end else if (sel_slow) begin
         next_rdata = slow_image;
      end else if (sel_source) begin
         next_rdata = source_image;
      end
   end

   always @(posedge sys_clk) begin
      if (!rst_b) begin
         reg_rdata <= `VFI_RST_BYTE;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

endmodule // vfi_voltage_fault_irq

//--- test/testbench.sv
// Purpose: self-checking bench for the voltage fault status block
// Assumes: fault inputs need three edges to reach the flags
// Notes:   rows first, then hand-written cases
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [2:0] fc, sa, fe, se;
      logic [7:0] fo, so, em, ef, es;
   } vfi_row_t;
   logic       sys_clk = 1'b0, rst_b = 1'b0, bank_select = 1'b0;
   logic [2:0] fast_undervolt_cmp = 3'h0, slow_undervolt_adc = 3'h0;
   logic [2:0] fast_undervolt_irq_enable = 3'h7, slow_undervolt_irq_enable = 3'h7;
   logic [7:0] fast_overvolt_flags = 8'h00, slow_overvolt_flags = 8'h00, reg_addr, reg_wdata, reg_rdata;
   logic [2:0] fast_undervolt_flags_out, slow_undervolt_flags_out;
   logic       reg_wr, reg_rd, reg_hit, global_irq_monitor;
   int         bad_count = 0, checks_done = 0, cyc = 0;
   vfi_row_t   r;
   vfi_row_t   rows [5] = '{'{3'h1, 3'h0, 3'h7, 3'h7, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00},
      '{3'h0, 3'h4, 3'h7, 3'h7, 8'h00, 8'h00, 8'h02, 8'h00, 8'h08},
      '{3'h6, 3'h3, 3'h7, 3'h7, 8'h10, 8'h00, 8'h07, 8'h0c, 8'h06},
      '{3'h7, 3'h7, 3'h5, 3'h2, 8'h00, 8'h01, 8'h0b, 8'h0a, 8'h04},
      '{3'h0, 3'h0, 3'h0, 3'h0, 8'h00, 8'h80, 8'h08, 8'h00, 8'h00}};
   vfi_voltage_fault_irq dut (.*);
   vfi_host host (.*);
   always #2 sys_clk = ~sys_clk;
   // ****************************************
   // checks and run control
   // ****************************************
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      host.rd(a, v);
      chk(v, e);
   endtask
   task automatic final_report;
      if (bad_count == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // limit well above the roughly 230 cycles of the run
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         bad_count++;
         final_report;
      end
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      foreach (rows[i]) begin
         r = rows[i];
         @(posedge sys_clk);
         {fast_undervolt_cmp, slow_undervolt_adc} <= {r.fc, r.sa};
         {fast_undervolt_irq_enable, slow_undervolt_irq_enable} <= {r.fe, r.se};
         {fast_overvolt_flags, slow_overvolt_flags} <= {r.fo, r.so};
         repeat (5) @(posedge sys_clk);
         {fast_undervolt_cmp, slow_undervolt_adc} <= 6'h00;
         repeat (4) @(posedge sys_clk);
         rc(8'h11, r.em);
         rc(8'h12, r.ef);
         rc(8'h14, r.es);
         chk({7'h00, global_irq_monitor}, {7'h00, |r.em});
         rc(8'h10, {7'h00, |r.em});
         host.wr(8'h12, 8'hff);
         host.wr(8'h14, 8'hff);
         rc(8'h12, 8'h00);
         rc(8'h14, 8'h00);
      end
      @(posedge sys_clk);
      {fast_undervolt_irq_enable, slow_undervolt_irq_enable} <= 6'h3f;
      {fast_undervolt_cmp, slow_undervolt_adc} <= {3'h1, 3'h4};
      repeat (5) @(posedge sys_clk);
      host.wr(8'h12, 8'hff);
      host.wr(8'h14, 8'hff);
      rc(8'h12, 8'h02);
      rc(8'h14, 8'h08);
      @(posedge sys_clk);
      {fast_undervolt_cmp, slow_undervolt_adc, bank_select} <= 7'h01;
      repeat (4) @(posedge sys_clk);
      host.wr(8'h12, 8'hff);
      rc(8'h12, 8'h00);
      @(posedge sys_clk);
      bank_select <= 1'b0;
      host.wr(8'h12, 8'h00);
      host.wr(8'h11, 8'hff);
      rc(8'h12, 8'h02);
      host.wr(8'h12, 8'hf1);
      rc(8'h12, 8'h02);
      host.wr(8'h12, 8'h02);
      rc(8'h12, 8'h00);
      rc(8'h14, 8'h08);
      rc(8'h13, 8'h00);
      @(posedge sys_clk);
      rst_b <= 1'b0;
      slow_undervolt_adc <= 3'h0;
      slow_overvolt_flags <= 8'h00;
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      rc(8'h11, 8'h00);
      rc(8'h12, 8'h00);
      rc(8'h14, 8'h00);
      final_report;
   end
endmodule // testbench

//--- test/vfi_checker.sv
// Purpose: port assertions for the voltage fault status block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every instance of the top module
`timescale 1ns/1ps
module vfi_checker (
   input wire       sys_clk,
   input wire       rst_b,
   input wire [2:0] fast_undervolt_irq_enable,
   input wire [2:0] slow_undervolt_irq_enable,
   input wire [7:0] fast_overvolt_flags,
   input wire [7:0] slow_overvolt_flags,
   input wire       bank_select,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_rdata,
   input wire       reg_hit,
   input wire [2:0] fast_undervolt_flags_out,
   input wire [2:0] slow_undervolt_flags_out,
   input wire       global_irq_monitor
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence s_rd(a);
      reg_rd && reg_hit && reg_addr == a;
   endsequence
   property p_glob;
      global_irq_monitor == (|fast_undervolt_flags_out || |slow_undervolt_flags_out
         || |fast_overvolt_flags || |slow_overvolt_flags);
   endproperty
   a_glob: assert property (p_glob) else $error("global source wrong");
   property p_hit;
      reg_hit == (!bank_select && reg_addr inside {8'h10, 8'h11, 8'h12, 8'h14});
   endproperty
   a_hit: assert property (p_hit) else $error("hit decode wrong");
   property p_keep;
      !reg_wr |=> &(fast_undervolt_flags_out | ~$past(fast_undervolt_flags_out)
         | ~$past(fast_undervolt_irq_enable));
   endproperty
   a_keep: assert property (p_keep) else $error("flag lost without write");
   property p_keeps;
      !reg_wr |=> &(slow_undervolt_flags_out | ~$past(slow_undervolt_flags_out)
         | ~$past(slow_undervolt_irq_enable));
   endproperty
   a_keeps: assert property (p_keeps) else $error("slow flag lost without write");
   property p_disf;
      1'b1 |=> (fast_undervolt_flags_out & ~$past(fast_undervolt_irq_enable)) == 3'h0;
   endproperty
   a_disf: assert property (p_disf) else $error("disabled fast flag set");
   property p_dis;
      1'b1 |=> (slow_undervolt_flags_out & ~$past(slow_undervolt_irq_enable)) == 3'h0;
   endproperty
   a_dis: assert property (p_dis) else $error("disabled flag set");
   property p_rdf;
      s_rd(8'h12) |=> reg_rdata == {4'h0, $past(fast_undervolt_flags_out), 1'b0};
   endproperty
   a_rdf: assert property (p_rdf) else $error("fast read wrong");
   property p_rds;
      s_rd(8'h14) |=> reg_rdata == {4'h0, $past(slow_undervolt_flags_out), 1'b0};
   endproperty
   a_rds: assert property (p_rds) else $error("slow read wrong");
   property p_rdm;
      s_rd(8'h11) |=> reg_rdata == {4'h0, |$past(slow_overvolt_flags), |$past(fast_overvolt_flags),
         |$past(slow_undervolt_flags_out), |$past(fast_undervolt_flags_out)};
   endproperty
   a_rdm: assert property (p_rdm) else $error("summary read wrong");
   property p_bank;
      reg_rd && bank_select |=> reg_rdata == 8'h00;
   endproperty
   a_bank: assert property (p_bank) else $error("other bank answered");
endmodule // vfi_checker
bind vfi_voltage_fault_irq vfi_checker u_chk (.*);

//--- test/vfi_host.sv
// Purpose: host model issuing byte register strobes
// Assumes: one request at a time
// Notes:   signals change only by nba at a rising edge
`timescale 1ns/1ps
module vfi_host (
   input  wire       sys_clk,
   input  wire [7:0] reg_rdata,
   output logic      reg_wr,
   output logic      reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      v = reg_rdata;
   endtask
endmodule // vfi_host
